// ===== hw/slpc_top.sv
// slpc_top: serdes quad and lane power control with tx level and rx equaliser settings
// assumes port status from ltssm logic on the same clock; axi4-lite register access
`timescale 1ns/1ps

module slpc_top
   import slpc_pkg::*;
(
   // clock and reset
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_rst_n,
   // axi4-lite slave
   input  wire logic [7:0]                    i_awaddr,
   input  wire logic                          i_awvalid,
   output logic                               o_awready,
   input  wire logic [31:0]                   i_wdata,
   input  wire logic [3:0]                    i_wstrb,
   input  wire logic                          i_wvalid,
   output logic                               o_wready,
   output logic [1:0]                         o_bresp,
   output logic                               o_bvalid,
   input  wire logic                          i_bready,
   input  wire logic [7:0]                    i_araddr,
   input  wire logic                          i_arvalid,
   output logic                               o_arready,
   output logic [31:0]                        o_rdata,
   output logic [1:0]                         o_rresp,
   output logic                               o_rvalid,
   input  wire logic                          i_rready,
   // port and ltssm status (per port)
   input  wire logic [NUM_PORTS-1:0]          i_port_in_detect,
   input  wire logic [NUM_PORTS-1:0]          i_port_link_up,
   input  wire logic [NUM_PORTS-1:0]          i_port_in_compliance,
   input  wire logic [NUM_PORTS-1:0]          i_port_gen2,
   // per lane status from ltssm
   input  wire logic [NUM_LANES-1:0]          i_lane_partner_det,
   input  wire logic [NUM_LANES-1:0]          i_lane_active,
   // serdes controls
   output logic [NUM_QUADS-1:0]               o_quad_deep_pd,
   output slpc_lane_pwr_t [NUM_LANES-1:0]     o_lane_pwr,
   output logic [NUM_LANES-1:0]               o_lane_tx_idle,
   output logic [NUM_LANES-1:0]               o_lane_rx_term,
   output slpc_tx_t [NUM_LANES-1:0]           o_lane_tx,
   output slpc_rxeq_t [NUM_LANES-1:0]         o_lane_rxeq
);
   import slpc_pkg::*;

   // =====================================================
   // fixed lane-to-port map: quad0 one x4 port, quads1..2 one x8 port,
   // quad3 split into four x1 ports (ports 2..5); ports 6,7 unmapped
   localparam logic [2:0] LANE_PORT [NUM_LANES] = '{
      3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1,
      3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
   // wide ports own quads (x4/x8); narrow ports own lanes only
   localparam logic [NUM_PORTS-1:0] PORT_WIDE = 8'h03;

   // =====================================================
   // registers
   logic [NUM_PORTS-1:0]  port_en_reg;
   logic [NUM_QUADS-1:0]  quad_force_off_reg;
   logic [NUM_QUADS-1:0]  low_swing_enable_reg;
   logic [2:0]            transmit_margin_select_reg;
   logic [3:0]            gen2_lowswing_drive_code_reg;
   logic [7:0]            rx_equalizer_lane_control_reg [NUM_LANES];
   logic [NUM_LANES-1:0]  lane_used_reg;
   logic [NUM_PORTS-1:0]  port_detect_d_reg;

   // =====================================================
   // axi4-lite write path
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic        wstrb0_reg;
   logic        wr_fire;
   logic        wr_hit;

   assign o_awready = !aw_hold_reg && !o_bvalid;
   assign o_wready  = !w_hold_reg && !o_bvalid;
   assign wr_fire   = aw_hold_reg && w_hold_reg && !o_bvalid;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb0_reg  <= 1'b0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= i_awaddr;
         end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= i_wdata;
            // strobe is only valid with its data beat, so keep it alongside
            wstrb0_reg <= i_wstrb[0];
         end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_hit = (awaddr_reg == SLPC_PORT_EN_OFF) || (awaddr_reg == SLPC_QUAD_CTL_OFF) ||
               (awaddr_reg == SLPC_LINK_CTL2_OFF) ||
               (awaddr_reg[7:6] == 2'h1 && awaddr_reg[1:0] == 2'h0);
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_bvalid <= 1'b0;
         o_bresp  <= 2'h0;
      end else if (wr_fire) begin
         o_bvalid <= 1'b1;
         o_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   // control registers; byte lane 0 carries every field
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         port_en_reg                  <= SLPC_PORT_EN_RST;
         quad_force_off_reg           <= '0;
         low_swing_enable_reg         <= '0;
         transmit_margin_select_reg   <= SLPC_TM_RST;
         gen2_lowswing_drive_code_reg <= SLPC_G2CODE_RST;
      end else if (wr_fire && wstrb0_reg) begin
         unique case (awaddr_reg)
            SLPC_PORT_EN_OFF:   port_en_reg <= wdata_reg[7:0];
            SLPC_QUAD_CTL_OFF: begin
               quad_force_off_reg   <= wdata_reg[SLPC_QFORCE_POS +: NUM_QUADS];
               low_swing_enable_reg <= wdata_reg[SLPC_LSE_POS +: NUM_QUADS];
            end
            SLPC_LINK_CTL2_OFF: begin
               transmit_margin_select_reg   <= wdata_reg[SLPC_TM_POS +: 3];
               gen2_lowswing_drive_code_reg <= wdata_reg[SLPC_G2CODE_POS +: 4];
            end
            default: ;
         endcase
      end
   end

   // =====================================================
   // per-lane logic
   logic [NUM_QUADS-1:0] quad_all_dis;
   logic [NUM_QUADS-1:0] quad_wide_dis;
   logic [NUM_QUADS-1:0] quad_has_en;

   generate
      for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
         localparam int Q = l / LANES_PER_Q;
         logic [2:0] p;
         logic       en;
         logic       low_swing_enable;
         assign p   = LANE_PORT[l];
         assign en  = port_en_reg[p];
         // merged port: low swing only when every serdes of the port has its bit set
         assign low_swing_enable = low_swing_enable_reg[Q] &&
                      (p != 3'h1 || (low_swing_enable_reg[1] && low_swing_enable_reg[2]));

         always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
               rx_equalizer_lane_control_reg[l] <= SLPC_RXEQ_RST;
            end else if (wr_fire && wstrb0_reg &&
                         awaddr_reg == SLPC_RXEQ_BASE_OFF + 8'(l * 4)) begin
               rx_equalizer_lane_control_reg[l] <= wdata_reg[7:0];
            end
         end

         // used-lane capture on retrain out of detect
         always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
               lane_used_reg[l] <= 1'b0;
            end else if (port_detect_d_reg[p] && !i_port_in_detect[p]) begin
               lane_used_reg[l] <= i_lane_partner_det[l];
            end
         end

         always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
               o_lane_pwr[l]     <= SLPC_LANE_DEEP;
               o_lane_tx_idle[l] <= 1'b1;
               o_lane_rx_term[l] <= 1'b0;
            end else if (quad_force_off_reg[Q]) begin
               o_lane_pwr[l]     <= SLPC_LANE_OFF;
               o_lane_tx_idle[l] <= 1'b1;
               o_lane_rx_term[l] <= 1'b0;
            end else if (!en) begin
               o_lane_pwr[l]     <= SLPC_LANE_DEEP;
               o_lane_tx_idle[l] <= 1'b1;
               o_lane_rx_term[l] <= 1'b0;
            end else if (i_port_in_detect[p]) begin
               o_lane_pwr[l]     <= SLPC_LANE_ON;
               o_lane_tx_idle[l] <= 1'b1;
               o_lane_rx_term[l] <= 1'b1;
            end else if (!lane_used_reg[l]) begin
               o_lane_pwr[l]     <= SLPC_LANE_OFF;
               o_lane_tx_idle[l] <= 1'b1;
               o_lane_rx_term[l] <= 1'b0;
            end else if (i_port_link_up[p] && !i_lane_active[l]) begin
               o_lane_pwr[l]     <= SLPC_LANE_PARTIAL;
               o_lane_tx_idle[l] <= 1'b1;
               o_lane_rx_term[l] <= 1'b1;
            end else begin
               o_lane_pwr[l]     <= SLPC_LANE_ON;
               o_lane_tx_idle[l] <= 1'b0;
               o_lane_rx_term[l] <= 1'b1;
            end
         end

         always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
               o_lane_tx[l]   <= '0;
               o_lane_rxeq[l] <= '0;
            end else begin
               o_lane_rxeq[l].eq_zero  <= rx_equalizer_lane_control_reg[l][SLPC_EQZ_POS +: 4];
               o_lane_rxeq[l].eq_boost <= rx_equalizer_lane_control_reg[l][SLPC_EQB_POS +: 4];
               o_lane_tx[l].low_swing  <= low_swing_enable;
               o_lane_tx[l].margin     <= transmit_margin_select_reg;
               o_lane_tx[l].deemph_off <= low_swing_enable;
               // margin always follows the margin select field; gen2 low swing outside compliance uses the drive code
               o_lane_tx[l].drive_code <= (low_swing_enable && i_port_gen2[p] && !i_port_in_compliance[p]) ?
                                          gen2_lowswing_drive_code_reg : 4'h0;
            end
         end
      end

      for (genvar q = 0; q < NUM_QUADS; q++) begin : g_quad
         logic [LANES_PER_Q-1:0] dis;
         logic [LANES_PER_Q-1:0] wide;
         for (genvar k = 0; k < LANES_PER_Q; k++) begin : g_k
            assign dis[k]  = !port_en_reg[LANE_PORT[q*LANES_PER_Q+k]];
            assign wide[k] = PORT_WIDE[LANE_PORT[q*LANES_PER_Q+k]];
         end
         assign quad_all_dis[q]  = &dis;
         assign quad_wide_dis[q] = |(dis & wide);
         assign quad_has_en[q]   = |(~dis);

         always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
               o_quad_deep_pd[q] <= 1'b1;
            end else begin
               // force-off overrides; else quad follows its ports
               o_quad_deep_pd[q] <= quad_force_off_reg[q] ||
                                    (!quad_has_en[q] && (quad_all_dis[q] || quad_wide_dis[q]));
            end
         end
      end
   endgenerate

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         port_detect_d_reg <= '0;
      end else begin
         port_detect_d_reg <= i_port_in_detect;
      end
   end

   // =====================================================
   // axi4-lite read path
   logic [31:0] rd_mux;
   logic        rd_hit;
   logic [3:0]  rd_idx;

   assign o_arready = !o_rvalid;
   assign rd_idx    = i_araddr[5:2];

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      if (i_araddr == SLPC_PORT_EN_OFF) begin
         rd_mux[7:0] = port_en_reg;
      end else if (i_araddr == SLPC_QUAD_CTL_OFF) begin
         rd_mux[SLPC_QFORCE_POS +: NUM_QUADS] = quad_force_off_reg;
         rd_mux[SLPC_LSE_POS +: NUM_QUADS]    = low_swing_enable_reg;
      end else if (i_araddr == SLPC_LINK_CTL2_OFF) begin
         rd_mux[SLPC_TM_POS +: 3]     = transmit_margin_select_reg;
         rd_mux[SLPC_G2CODE_POS +: 4] = gen2_lowswing_drive_code_reg;
      end else if (i_araddr == SLPC_LANE_USED_OFF) begin
         rd_mux[NUM_LANES-1:0] = lane_used_reg;
      end else if (i_araddr == SLPC_QUAD_STAT_OFF) begin
         rd_mux[NUM_QUADS-1:0] = o_quad_deep_pd;
      end else if (i_araddr[7:6] == 2'h1 && i_araddr[1:0] == 2'h0) begin
         rd_mux[7:0] = rx_equalizer_lane_control_reg[rd_idx];
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0000_0000;
         o_rresp  <= 2'h0;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rdata  <= rd_mux;
         o_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

   // =====================================================
   // checks
   chk_force_quad_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      quad_force_off_reg[0] |=> o_quad_deep_pd[0])
      else $error("forced quad not powered down");
   chk_force_lanes_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      quad_force_off_reg[3] |=> (o_lane_pwr[12] == SLPC_LANE_OFF && o_lane_pwr[15] == SLPC_LANE_OFF))
      else $error("shared quad lanes not off");
   chk_enabled_quad_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (port_en_reg[0] && !quad_force_off_reg[0]) |=> !o_quad_deep_pd[0])
      else $error("enabled port quad off");
   chk_wide_dis_deep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !port_en_reg[1] |=> (o_quad_deep_pd[1] && o_quad_deep_pd[2]))
      else $error("x8 quads not deep");
   chk_narrow_lane_deep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (!port_en_reg[2] && !quad_force_off_reg[3]) |=> o_lane_pwr[12] == SLPC_LANE_DEEP)
      else $error("x1 lane not deep");
   chk_all_narrow_dis: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (port_en_reg[5:2] == 4'h0) |=> o_quad_deep_pd[3])
      else $error("quad with all ports off not deep");
   chk_lowswing_deemph: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      low_swing_enable_reg[0] |=> o_lane_tx[0].deemph_off)
      else $error("deemphasis on in low swing");
   chk_rxeq_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ##1 o_lane_rxeq[3].eq_zero == $past(rx_equalizer_lane_control_reg[3][3:0]))
      else $error("rx eq zero not routed");
   chk_unused_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (port_en_reg[0] && !quad_force_off_reg[0] && !i_port_in_detect[0] && !lane_used_reg[1])
      |=> o_lane_pwr[1] == SLPC_LANE_OFF)
      else $error("unused lane not off");
   cov_force_off: cover property (@(posedge i_ref_clk) quad_force_off_reg[2] ##1 !quad_force_off_reg[2]);
   cov_downconfig: cover property (@(posedge i_ref_clk) o_lane_pwr[5] == SLPC_LANE_PARTIAL);
   cov_retrain: cover property (@(posedge i_ref_clk) port_detect_d_reg[0] && !i_port_in_detect[0]);

endmodule : slpc_top

// ===== hw/slpc_pkg.sv
// slpc_pkg: constants and types for the serdes lane power control block
// assumes a fixed arrangement of quads and ports as given below
package slpc_pkg;

   // =====================================================
   // geometry
   localparam int NUM_QUADS    = 4;
   localparam int LANES_PER_Q  = 4;
   localparam int NUM_LANES    = NUM_QUADS * LANES_PER_Q;
   localparam int NUM_PORTS    = 8;

   // =====================================================
   // lane power encodings driven toward each serdes lane
   typedef enum logic [1:0] {
      SLPC_LANE_ON      = 2'h0,
      SLPC_LANE_PARTIAL = 2'h1,
      SLPC_LANE_DEEP    = 2'h2,
      SLPC_LANE_OFF     = 2'h3
   } slpc_lane_pwr_t;

   // =====================================================
   // register offsets (byte addresses)
   localparam logic [7:0] SLPC_PORT_EN_OFF    = 8'h00;
   localparam logic [7:0] SLPC_QUAD_CTL_OFF   = 8'h04;
   localparam logic [7:0] SLPC_LINK_CTL2_OFF  = 8'h08;
   localparam logic [7:0] SLPC_LANE_USED_OFF  = 8'h0c;
   localparam logic [7:0] SLPC_QUAD_STAT_OFF  = 8'h10;
   localparam logic [7:0] SLPC_RXEQ_BASE_OFF  = 8'h40;

   // =====================================================
   // field positions
   localparam int SLPC_QFORCE_POS  = 0;
   localparam int SLPC_LSE_POS     = 4;
   localparam int SLPC_TM_POS      = 0;
   localparam int SLPC_G2CODE_POS  = 4;
   localparam int SLPC_EQZ_POS     = 0;
   localparam int SLPC_EQB_POS     = 4;

   // =====================================================
   // reset values and drive code limits
   localparam logic [7:0] SLPC_PORT_EN_RST = 8'hff;
   localparam logic [3:0] SLPC_G2CODE_RST  = 4'h8;
   localparam logic [2:0] SLPC_TM_RST      = 3'h0;
   localparam logic [7:0] SLPC_RXEQ_RST    = 8'h00;
   localparam logic [3:0] SLPC_G2CODE_MIN  = 4'h0;
   localparam logic [3:0] SLPC_G2CODE_MAX  = 4'hf;

   // =====================================================
   // per-lane settings toward the receiver/transmitter
   typedef struct packed {
      logic [3:0] eq_zero;
      logic [3:0] eq_boost;
   } slpc_rxeq_t;

   typedef struct packed {
      logic       low_swing;
      logic       deemph_off;
      logic [2:0] margin;
      logic [3:0] drive_code;
   } slpc_tx_t;

endpackage : slpc_pkg

// ===== verification/slpc_ltssm_model.sv
// slpc_ltssm_model: port training logic and lane status seen by the power control block
// assumes the bench calls its tasks; all changes land just after a rising edge
`timescale 1ns/1ps

module slpc_ltssm_model
   import slpc_pkg::*;
(
   // clock
   input  wire logic                 i_ref_clk,
   // port and lane status toward the block
   output logic [NUM_PORTS-1:0]      o_port_in_detect,
   output logic [NUM_PORTS-1:0]      o_port_link_up,
   output logic [NUM_PORTS-1:0]      o_port_in_compliance,
   output logic [NUM_PORTS-1:0]      o_port_gen2,
   output logic [NUM_LANES-1:0]      o_lane_partner_det,
   output logic [NUM_LANES-1:0]      o_lane_active
);
   initial begin
      o_port_in_detect     = '0;
      o_port_link_up       = '0;
      o_port_in_compliance = '0;
      o_port_gen2          = '0;
      o_lane_partner_det   = '1;
      o_lane_active        = '0;
   end

   // =====================================================
   // detect, then leave detect with partner mask m; retrain goes through here too
   task train(input int p, input logic [NUM_LANES-1:0] m);
      @(posedge i_ref_clk);
      o_port_link_up[p]   <= 1'b0;
      o_port_in_detect[p] <= 1'b1;
      o_lane_partner_det  <= m;
      repeat (2) @(posedge i_ref_clk);
      o_port_in_detect[p] <= 1'b0;
      @(posedge i_ref_clk);
      // detect result no longer valid: show the inverse
      o_lane_partner_det  <= ~m;
      o_port_link_up[p]   <= 1'b1;
      o_lane_active       <= m;
   endtask : train

   // link width change while up
   task narrow(input logic [NUM_LANES-1:0] m);
      @(posedge i_ref_clk);
      o_lane_active <= m;
   endtask : narrow

   task mode(input int p, input logic comp, input logic g2);
      @(posedge i_ref_clk);
      o_port_in_compliance[p] <= comp;
      o_port_gen2[p]          <= g2;
   endtask : mode
endmodule : slpc_ltssm_model

// ===== verification/testbench.sv
// testbench: register and port-state sequences against the power control block
// assumes slpc_top with its fixed quad/port layout and axi4-lite registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("Error %s expected %h seen %h", n, e, g); end end

module testbench;
   import slpc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0, rd;
   logic [3:0] wstrb = '0;
   logic [1:0] rsp;
   logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [NUM_PORTS-1:0] det, lup, comp, g2;
   logic [NUM_LANES-1:0] pdet, act, tx_idle, rx_term;
   logic [NUM_QUADS-1:0] qpd;
   slpc_lane_pwr_t [NUM_LANES-1:0] lpwr;
   slpc_tx_t [NUM_LANES-1:0] ltx;
   slpc_rxeq_t [NUM_LANES-1:0] leq;
   int err_count = 0, check_count = 0;
   logic [7:0] pen_tab [5] = '{8'hfe, 8'hfc, 8'hf8, 8'hc0, 8'hff};
   logic [3:0] qpd_tab [5] = '{4'h1, 4'h7, 4'h7, 4'hf, 4'h0};

   always #2.5 clk = ~clk;

   slpc_ltssm_model u_ltssm (.i_ref_clk(clk), .o_port_in_detect(det), .o_port_link_up(lup),
      .o_port_in_compliance(comp), .o_port_gen2(g2), .o_lane_partner_det(pdet),
      .o_lane_active(act));

   slpc_top dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(aw_rdy), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
      .o_wready(w_rdy), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(ar_rdy), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_port_in_detect(det),
      .i_port_link_up(lup), .i_port_in_compliance(comp), .i_port_gen2(g2),
      .i_lane_partner_det(pdet), .i_lane_active(act), .o_quad_deep_pd(qpd),
      .o_lane_pwr(lpwr), .o_lane_tx_idle(tx_idle), .o_lane_rx_term(rx_term),
      .o_lane_tx(ltx), .o_lane_rxeq(leq));

   // =====================================================
   // closing report
   task complete_run;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   // =====================================================
   // axi4-lite master; ready is looked at between edges, valid dropped after the taking edge
   task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic ta, tw, tb;
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= 4'hf;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      tb = 1'b0;
      for (n = 0; n < 200 && !tb; n++) begin
         @(negedge clk);
         ta = awvalid && aw_rdy; tw = wvalid && w_rdy; tb = bready && bvalid; r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
      if (!tb) begin err_count++; complete_run(); end
   endtask : axi_wr

   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ta, tr;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      tr = 1'b0;
      for (n = 0; n < 200 && !tr; n++) begin
         @(negedge clk);
         ta = arvalid && ar_rdy; tr = rready && rvalid; d = rdata; r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end
      if (!tr) begin err_count++; complete_run(); end
   endtask : axi_rd

   // registered lane outputs settle one cycle after their cause
   task settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : settle

   // =====================================================
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      axi_rd(SLPC_PORT_EN_OFF, rd, rsp);
      `CHK("port_en", 32'h000000ff, rd)
      axi_rd(SLPC_LINK_CTL2_OFF, rd, rsp);
      `CHK("link_ctl2", 32'h00000080, rd)
      axi_rd(8'h20, rd, rsp);
      `CHK("rd_unmapped", 2'h2, rsp)
      axi_wr(8'h3c, 32'h0000ffff, rsp);
      `CHK("wr_unmapped", 2'h2, rsp)
      `CHK("quad_on", 4'h0, qpd)
      `CHK("lane0_unused", SLPC_LANE_OFF, lpwr[0])
      // train port0 with a partner on two lanes
      u_ltssm.train(0, 16'h0003);
      settle();
      `CHK("lane1_used", SLPC_LANE_ON, lpwr[1])
      `CHK("lane2_unused", SLPC_LANE_OFF, lpwr[2])
      axi_rd(SLPC_LANE_USED_OFF, rd, rsp);
      `CHK("lane_used", 32'h00000003, rd)
      u_ltssm.narrow(16'h0001);
      settle();
      `CHK("lane1_partial", SLPC_LANE_PARTIAL, lpwr[1])
      `CHK("lane1_idle", 1'b1, tx_idle[1])
      `CHK("lane1_term", 1'b1, rx_term[1])
      `CHK("lane0_on", SLPC_LANE_ON, lpwr[0])
      u_ltssm.train(0, 16'h000f);
      settle();
      `CHK("lane3_retrained", SLPC_LANE_ON, lpwr[3])
      // forced quad power-down, on a single-port and on a shared quad
      axi_wr(SLPC_QUAD_CTL_OFF, 32'h00000009, rsp);
      settle();
      `CHK("quad_forced", 4'h9, qpd)
      `CHK("shared_lane_off", SLPC_LANE_OFF, lpwr[14])
      axi_rd(SLPC_QUAD_STAT_OFF, rd, rsp);
      `CHK("quad_stat", 32'h00000009, rd)
      axi_wr(SLPC_QUAD_CTL_OFF, 32'h00000000, rsp);
      settle();
      `CHK("quad_released", 4'h0, qpd)
      `CHK("lane0_back", SLPC_LANE_ON, lpwr[0])
      // disabling ports of each width
      for (int i = 0; i < 5; i++) begin
         axi_wr(SLPC_PORT_EN_OFF, {24'h0, pen_tab[i]}, rsp);
         settle();
         `CHK("quad_pd", qpd_tab[i], qpd)
         if (i == 2) `CHK("lane12_deep", SLPC_LANE_DEEP, lpwr[12])
      end
      // low swing compliance on port0
      axi_wr(SLPC_QUAD_CTL_OFF, 32'h00000010, rsp);
      axi_wr(SLPC_LINK_CTL2_OFF, 32'h00000083, rsp);
      u_ltssm.mode(0, 1'b1, 1'b0);
      settle();
      `CHK("tx_compl", 9'h1b0, ltx[0])
      u_ltssm.mode(0, 1'b0, 1'b1);
      for (int c = 0; c < 2; c++) begin
         axi_wr(SLPC_LINK_CTL2_OFF, c ? 32'h000000f0 : 32'h00000000, rsp);
         settle();
         `CHK("drive_code", c ? SLPC_G2CODE_MAX : SLPC_G2CODE_MIN, ltx[0].drive_code)
      end
      // merged port needs both enable bits
      axi_wr(SLPC_QUAD_CTL_OFF, 32'h00000020, rsp);
      settle();
      `CHK("lse_one_bit", 1'b0, ltx[4].low_swing)
      axi_wr(SLPC_QUAD_CTL_OFF, 32'h00000060, rsp);
      settle();
      `CHK("lse_both_bits", 1'b1, ltx[4].low_swing)
      // per-lane receiver equaliser
      axi_wr(SLPC_RXEQ_BASE_OFF + 8'h14, 32'h000000a5, rsp);
      settle();
      `CHK("eq_zero", 4'h5, leq[5].eq_zero)
      `CHK("eq_boost", 4'ha, leq[5].eq_boost)
      `CHK("eq_other", 8'h00, leq[6])
      axi_rd(SLPC_RXEQ_BASE_OFF + 8'h14, rd, rsp);
      `CHK("eq_read", 32'h000000a5, rd)
      complete_run();
   end
endmodule : testbench
